// [verilog/exc_unit_pkg.sv]
package exc_unit_pkg;

    // Vector numbers
    localparam logic [7:0] VEC_DIVIDE_ERROR = 8'h00;
    localparam logic [7:0] VEC_DEBUG        = 8'h01;
    localparam logic [7:0] VEC_NMI          = 8'h02;
    localparam logic [7:0] VEC_PAGE_FAULT   = 8'h0E;

    // Error code field positions
    localparam int EC_EXT_BIT   = 0;
    localparam int EC_GATE_BIT  = 1;
    localparam int EC_LOCAL_BIT = 2;
    localparam int EC_INDEX_LSB = 3;
    localparam int INDEX_W      = 13;

    // Debug cause bit positions in the debug status register
    localparam int DBG_FETCH_BIT  = 0;
    localparam int DBG_DATA_BIT   = 1;
    localparam int DBG_IO_BIT     = 2;
    localparam int DBG_GD_BIT     = 3;
    localparam int DBG_STEP_BIT   = 4;
    localparam int DBG_TASK_BIT   = 5;
    localparam int DBG_INT1_BIT   = 6;
    localparam int DBG_W          = 7;

    // AXI4-Lite register byte offsets
    localparam logic [7:0] REG_CTRL        = 8'h00;
    localparam logic [7:0] REG_DEBUG_STAT  = 8'h04;
    localparam logic [7:0] REG_LAST_VECTOR = 8'h08;
    localparam logic [7:0] REG_LAST_CODE   = 8'h0C;
    localparam logic [7:0] REG_PENDING     = 8'h10;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Control register field positions and reset value
    localparam int          CTRL_ENABLE_BIT = 0;
    localparam int          CTRL_GATE32_BIT = 1;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0003;

    // Source of a segment-related exception request
    typedef enum logic [1:0] {
        SRC_INTERNAL,
        SRC_MASKABLE_PIN,
        SRC_LOCAL_PINS,
        SRC_SOFT_INT
    } src_type;

    // Segment-related fault request from the core
    typedef struct packed {
        logic               valid;
        logic [7:0]         vector;
        logic               has_code;
        logic               seg_related;
        logic               null_ref;
        logic               external;
        logic               gate_ref;
        logic               local_ref;
        logic [INDEX_W-1:0] index;
        src_type            source;
    } seg_req_type;

    // Delivery handed to the stack push sequencer
    typedef struct packed {
        logic        valid;
        logic [7:0]  vector;
        logic        push_code;
        logic        code_dword;
        logic [31:0] code;
        logic        ip_next;
    } delivery_type;

endpackage

// [verilog/exc_unit.sv]
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
module exc_unit
    import exc_unit_pkg::*;
(
    input  wire logic               ref_clk_in,
    input  wire logic               srst_in,
    input  wire seg_req_type        seg_req_in,
    input  wire logic [31:0]        pf_code_in,
    input  wire logic               div_zero_in,
    input  wire logic               div_overflow_in,
    input  wire logic [DBG_W-1:0]   dbg_cond_in,
    input  wire logic               insn_boundary_in,
    input  wire logic               insn_done_in,
    input  wire logic               nmi_pin_in,
    input  wire logic               nmi_ctrl_req_in,
    input  wire logic               push_ready_in,
    output logic                    seg_req_ready_out,
    output delivery_type            delivery_out,
    output logic [DBG_W-1:0]        debug_status_reg_out,
    output logic                    s_axi_awready,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_wready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_bvalid,
    output logic [1:0]              s_axi_bresp,
    input  wire logic               s_axi_bready,
    input  wire logic [7:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic                    s_axi_rvalid,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    input  wire logic               s_axi_rready
);

    localparam logic [DBG_W-1:0] DBG_FAULT_MASK =
        DBG_W'((1 << DBG_FETCH_BIT) | (1 << DBG_GD_BIT));

    // Pin synchronisers: first stage is read only by the second
    logic nmi_meta;
    logic nmi_sync;
    logic nmi_sync_d;
    logic ctrl;
    logic [31:0] ctrl_reg;

    // Edge detect follows the second stage so a long pin level gives one request
    always_ff @(posedge ref_clk_in)
    begin
        nmi_meta   <= nmi_pin_in;
        nmi_sync   <= nmi_meta;
        nmi_sync_d <= srst_in ? 1'b0 : nmi_sync;
    end

    // Pending flags; set wins over clear on the same edge
    logic          seg_pend;
    seg_req_type   seg_hold;
    logic          de_pend;
    logic          nmi_pend;
    logic [DBG_W-1:0] dbg_pend;
    logic          busy;
    logic          take_nmi;
    logic          take_de;
    logic          take_dbg_fault;
    logic          take_dbg_trap;
    logic          take_seg;
    logic          enable;
    logic          gate32;

    // Write-path state, declared ahead of the debug status logic that reads it
    logic          aw_have;
    logic          w_have;
    logic [7:0]    wr_addr;
    logic          wr_fire;
    logic [31:0]   wdata_hold;
    logic [3:0]    wstrb_hold;

    // Deliveries stop while disabled; pending sources wait and nothing is lost
    assign enable = ctrl_reg[CTRL_ENABLE_BIT];
    assign gate32 = ctrl_reg[CTRL_GATE32_BIT];
    assign ctrl   = enable && !busy;

    // Priority: faults on the current instruction first, then traps and the
    // non-maskable event, both only once the instruction has completed
    always_comb
    begin
        take_de        = ctrl && de_pend;
        take_dbg_fault = ctrl && !take_de && |(dbg_pend & DBG_FAULT_MASK);
        take_seg       = ctrl && !take_de && !take_dbg_fault && seg_pend;
        take_dbg_trap  = ctrl && !take_de && !take_dbg_fault && !take_seg
                         && insn_done_in && |(dbg_pend & ~DBG_FAULT_MASK);
        take_nmi       = ctrl && !take_de && !take_dbg_fault && !take_seg
                         && !take_dbg_trap && nmi_pend
                         && insn_boundary_in && insn_done_in;
    end

    // Divide error catches either divisor zero or quotient overflow
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            de_pend <= 1'b0;
        else if (div_zero_in || div_overflow_in)
            de_pend <= 1'b1;
        else if (take_de)
            de_pend <= 1'b0;
    end

    // Non-maskable request from pin edge or from the interrupt controller
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            nmi_pend <= 1'b0;
        else if ((nmi_sync && !nmi_sync_d) || nmi_ctrl_req_in)
            nmi_pend <= 1'b1;
        else if (take_nmi)
            nmi_pend <= 1'b0;
    end

    // Debug conditions pend per cause; only the class being taken clears
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            dbg_pend <= '0;
        else if (take_dbg_fault)
            dbg_pend <= (dbg_pend & ~DBG_FAULT_MASK) | dbg_cond_in;
        else if (take_dbg_trap)
            dbg_pend <= (dbg_pend & DBG_FAULT_MASK) | dbg_cond_in;
        else
            dbg_pend <= dbg_pend | dbg_cond_in;
    end

    // Segment request is held until delivered; ready drops while held
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            seg_pend <= 1'b0;
            seg_hold <= '0;
        end
        else if (seg_req_in.valid && seg_req_ready_out)
        begin
            seg_pend <= 1'b1;
            seg_hold <= seg_req_in;
        end
        else if (take_seg)
            seg_pend <= 1'b0;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            seg_req_ready_out <= 1'b0;
        else
            seg_req_ready_out <= !seg_pend && !(seg_req_in.valid && seg_req_ready_out);
    end

    // Error code for the segment-related format
    function automatic logic [31:0] seg_code(input seg_req_type r);
        logic [31:0] c;
        c = '0;
        if (r.seg_related && !r.null_ref)
        begin
            c[EC_EXT_BIT]   = r.external;
            c[EC_GATE_BIT]  = r.gate_ref;
            c[EC_LOCAL_BIT] = !r.gate_ref && r.local_ref;
            c[EC_INDEX_LSB +: INDEX_W] = r.index;
        end
        else
            c[EC_EXT_BIT] = 1'b0;
        return c;
    endfunction

    // Delivery builder; one vector per handshake with the push sequencer
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            delivery_out <= '0;
            busy         <= 1'b0;
        end
        else if (busy)
        begin
            if (push_ready_in)
            begin
                delivery_out.valid <= 1'b0;
                busy               <= 1'b0;
            end
        end
        else if (take_de)
        begin
            delivery_out <= '{1'b1, VEC_DIVIDE_ERROR, 1'b0, gate32,
                              32'h0000_0000, 1'b0};
            busy <= 1'b1;
        end
        else if (take_dbg_fault || take_dbg_trap)
        begin
            // Fault leaves the pointer on the cause, trap moves past it
            delivery_out <= '{1'b1, VEC_DEBUG, 1'b0, gate32,
                              32'h0000_0000, take_dbg_trap};
            busy <= 1'b1;
        end
        else if (take_seg)
        begin
            delivery_out.valid      <= 1'b1;
            delivery_out.vector     <= seg_hold.vector;
            // The pusher places the code after the saved pointer
            delivery_out.push_code  <= seg_hold.has_code
                                       && seg_hold.source == SRC_INTERNAL;
            delivery_out.code_dword <= gate32;
            // Upper half stays reserved as zero in the segment format
            delivery_out.code       <= (seg_hold.vector == VEC_PAGE_FAULT)
                                       ? pf_code_in : seg_code(seg_hold);
            delivery_out.ip_next    <= seg_hold.source != SRC_INTERNAL;
            busy <= 1'b1;
        end
        else if (take_nmi)
        begin
            delivery_out <= '{1'b1, VEC_NMI, 1'b0, gate32,
                              32'h0000_0000, 1'b1};
            busy <= 1'b1;
        end
    end

    // Debug status register records causes as they are delivered
    // A software write replaces the causes, but one taken in the same cycle is kept;
    // the held write word is used since the bus data may already have moved on
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            debug_status_reg_out <= '0;
        else if (wr_fire && wr_addr == REG_DEBUG_STAT && wstrb_hold[0])
            debug_status_reg_out <= wdata_hold[DBG_W-1:0]
                                    | (take_dbg_fault ? (dbg_pend & DBG_FAULT_MASK) : '0)
                                    | (take_dbg_trap ? (dbg_pend & ~DBG_FAULT_MASK) : '0);
        else if (take_dbg_fault)
            debug_status_reg_out <= debug_status_reg_out
                                    | (dbg_pend & DBG_FAULT_MASK);
        else if (take_dbg_trap)
            debug_status_reg_out <= debug_status_reg_out
                                    | (dbg_pend & ~DBG_FAULT_MASK);
    end

    // AXI4-Lite write path: address and data taken in either order
    // A new write waits while the previous response is still unanswered
    assign wr_fire = aw_have && w_have && !s_axi_bvalid;

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            wr_addr       <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_have && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
                w_have <= 1'b1;
            if (wr_fire)
            begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_addr == REG_CTRL || wr_addr == REG_DEBUG_STAT)
                                ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Write data register, kept apart from the handshake
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            wdata_hold <= '0;
            wstrb_hold <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            wdata_hold <= s_axi_wdata;
            wstrb_hold <= s_axi_wstrb;
        end
    end

    // Control register; only byte lane 0 holds fields
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            ctrl_reg <= CTRL_RESET;
        else if (wr_fire && wr_addr == REG_CTRL && wstrb_hold[0])
            ctrl_reg <= {30'h0000_0000, wdata_hold[CTRL_GATE32_BIT:0]};
    end

    // Last delivered vector and code, for software inspection
    logic [31:0] rd_mux;

    always_comb
    begin
        case (s_axi_araddr)
            REG_CTRL:        rd_mux = ctrl_reg;
            REG_DEBUG_STAT:  rd_mux = {25'h000_0000, debug_status_reg_out};
            REG_LAST_VECTOR: rd_mux = {24'h00_0000, delivery_out.vector};
            REG_LAST_CODE:   rd_mux = delivery_out.code;
            REG_PENDING:     rd_mux = {20'h0_0000, seg_pend, de_pend, nmi_pend,
                                       busy, dbg_pend, 1'b0};
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // AXI4-Lite read path: one cycle after the address is taken
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= (s_axi_araddr <= REG_PENDING && s_axi_araddr[1:0] == 2'h0)
                                ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// [bench/exc_unit_sva.sv]
`timescale 1ns/100ps
module exc_unit_sva
    import exc_unit_pkg::*;
(
    input wire logic             ref_clk_in,
    input wire logic             srst_in,
    input wire seg_req_type      seg_req_in,
    input wire logic [DBG_W-1:0] dbg_cond_in,
    input wire logic             insn_boundary_in,
    input wire logic             insn_done_in,
    input wire logic             push_ready_in,
    input wire logic             seg_req_ready_out,
    input wire delivery_type     delivery_out,
    input wire logic [DBG_W-1:0] debug_status_reg_out
);
    // Short aliases for the delivery fields
    wire       dv  = delivery_out.valid;
    wire       pc  = delivery_out.push_code;
    wire       ipn = delivery_out.ip_next;
    wire [7:0] vec = delivery_out.vector;
    // Causes that make the debug exception a fault; all others are traps
    localparam logic [DBG_W-1:0] FAULT_CAUSES =
        DBG_W'((1 << DBG_FETCH_BIT) | (1 << DBG_GD_BIT));
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (srst_in);
    // Fixed shapes of the three low vectors
    chk_div_shape:
        assert property (dv && vec == VEC_DIVIDE_ERROR |-> !pc && !ipn)
        else $error("divide delivery shape wrong");
    chk_dbg_nocode:
        assert property (dv && vec == VEC_DEBUG |-> !pc)
        else $error("debug delivery has a code");
    chk_nmi_shape:
        assert property (dv && vec == VEC_NMI |-> !pc && ipn)
        else $error("nmi delivery shape wrong");
    // One delivery at a time, held until the push side takes it
    chk_dlv_hold:
        assert property (dv && !push_ready_in |=> dv && $stable(delivery_out))
        else $error("delivery changed before accept");
    chk_dlv_gap:
        assert property (dv && push_ready_in |=> !dv)
        else $error("no gap after accept");
    chk_seg_busy:
        assert property (seg_req_in.valid && seg_req_ready_out |=> !seg_req_ready_out)
        else $error("segment ready did not fall");
    // Delivery moments against core state
    chk_nmi_boundary:
        assert property ($rose(dv) && vec == VEC_NMI |-> $past(insn_boundary_in && insn_done_in))
        else $error("nmi off a boundary");
    chk_trap_done:
        assert property ($rose(dv) && vec == VEC_DEBUG && ipn |-> $past(insn_done_in))
        else $error("debug trap before done");
    // A debug delivery finds a cause of its own class already recorded
    chk_dbg_sticky:
        assert property ($rose(dv) && vec == VEC_DEBUG
                         |-> ((ipn ? ~FAULT_CAUSES : FAULT_CAUSES) & debug_status_reg_out) != '0)
        else $error("debug cause not recorded");
endmodule

bind exc_unit exc_unit_sva chk (
    .ref_clk_in, .srst_in, .seg_req_in, .dbg_cond_in, .insn_boundary_in, .insn_done_in,
    .push_ready_in, .seg_req_ready_out, .delivery_out, .debug_status_reg_out
);

// [bench/push_model.sv]
`timescale 1ns/100ps
module push_model
    import exc_unit_pkg::*;
(
    input  wire logic         ref_clk_in,
    input  wire logic         srst_in,
    input  wire delivery_type delivery_in,
    input  wire logic [3:0]   stall_in,
    output logic              push_ready_out,
    output delivery_type      last_out,
    output int                count_out
);
    logic [3:0] wait_cnt;
    // Accept after stall_in cycles; a one-cycle strobe avoids double pushes
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in || push_ready_out || !delivery_in.valid)
        begin
            push_ready_out <= 1'h0;
            wait_cnt       <= 4'h0;
        end
        else if (wait_cnt >= stall_in)
            push_ready_out <= 1'h1;
        else
            wait_cnt <= wait_cnt + 4'h1;
    end
    // Pointer pushed first, code after it; the handler drops the code itself
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            count_out <= 0;
        else if (delivery_in.valid && push_ready_out)
        begin
            last_out  <= delivery_in;
            count_out <= count_out + 1;
        end
    end
endmodule

// [bench/tb.sv]
`timescale 1ns/100ps
module tb;
    import exc_unit_pkg::*;
    localparam logic [7:0]  SEG_VEC = 8'h0B;
    localparam logic [12:0] IDX     = 13'h0ABC;
    logic              ref_clk_in = 1'h0;
    logic              srst_in = 1'h1;
    seg_req_type       seg_req_in = '0;
    logic [31:0]       pf_code_in = 32'h0;
    logic [9:0]        ev = 10'h000;
    logic              insn_boundary_in = 1'h1;
    logic              insn_done_in = 1'h1;
    logic              nmi_pin_in = 1'h0;
    logic [3:0]        stall = 4'h0;
    logic [7:0]        s_axi_awaddr = 8'h00;
    logic [7:0]        s_axi_araddr = 8'h00;
    logic [31:0]       s_axi_wdata = 32'h0;
    logic              s_axi_awvalid = 1'h0;
    logic              s_axi_wvalid = 1'h0;
    logic              s_axi_bready = 1'h0;
    logic              s_axi_arvalid = 1'h0;
    logic              s_axi_rready = 1'h0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic              push_ready_in, seg_req_ready_out, trap;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [31:0]       s_axi_rdata;
    logic [DBG_W-1:0]  debug_status_reg_out;
    delivery_type      delivery_out, got;
    int                taken;
    int                seen = 0;
    int                bad_count = 0;
    int                total_checks = 0;

    // Core clock
    always #5 ref_clk_in = ~ref_clk_in;

    // Pulses: ev[0] zero divisor, ev[1] overflow, ev[2] nmi request, ev[9:3] debug
    exc_unit uut (
        .ref_clk_in, .srst_in, .seg_req_in, .pf_code_in, .div_zero_in(ev[0]),
        .div_overflow_in(ev[1]), .dbg_cond_in(ev[9:3]), .insn_boundary_in, .insn_done_in,
        .nmi_pin_in, .nmi_ctrl_req_in(ev[2]), .push_ready_in, .seg_req_ready_out,
        .delivery_out, .debug_status_reg_out, .s_axi_awready, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_bvalid,
        .s_axi_bresp, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .s_axi_rready
    );
    push_model far_end (
        .ref_clk_in, .srst_in, .delivery_in(delivery_out), .stall_in(stall),
        .push_ready_out(push_ready_in), .last_out(got), .count_out(taken)
    );

    task automatic chk32(input string what, input logic [31:0] exp, act);
        total_checks++;
        if (act !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, act);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    task automatic summarize(input logic hung);
        if (hung)
            bad_count++;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic pulse(input logic [9:0] v);
        ev <= v;
        tick(1);
        ev <= 10'h000;
    endtask

    // Waits for the push side to take the next delivery, then compares it
    task automatic expect_dlv(input logic [7:0] vec, input logic pc, ipn);
        for (int n = 0; taken <= seen; n++)
        begin
            if (n == 200) summarize(1'h1);
            @(posedge ref_clk_in);
        end
        seen++;
        chk32("vector", {24'h0, vec}, {24'h0, got.vector});
        chk32("push_code", {31'h0, pc}, {31'h0, got.push_code});
        chk32("ip_next", {31'h0, ipn}, {31'h0, got.ip_next});
    endtask

    // Only the low word is meaningful in the word form
    task automatic expect_code(input logic [15:0] code, input logic dw);
        chk32("code", {16'h0, code}, {16'h0, got.code[15:0]});
        chk32("code_dword", {31'h0, dw}, {31'h0, got.code_dword});
    endtask

    task automatic seg(input logic [7:0] v, input logic sr, nul, e, g, l, input src_type s);
        int n;
        n = 0;
        seg_req_in <= '{1'h1, v, 1'h1, sr, nul, e, g, l, IDX, s};
        do
        begin
            @(posedge ref_clk_in);
            n++;
        end while (!seg_req_ready_out && n < 50);
        seg_req_in.valid <= 1'h0;
        if (n == 50) summarize(1'h1);
    endtask

    // One register access; bready or rready stays up until the answer
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        do
        begin
            @(posedge ref_clk_in);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 50);
        if (n == 50) summarize(1'h1);
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        chk32("resp", {30'h0, r}, {30'h0, wr ? s_axi_bresp : s_axi_rresp});
        if (!wr) chk32("rdata", d, s_axi_rdata);
    endtask

    initial
    begin
        tick(12);
        srst_in <= 1'h0;
        tick(3);
        // Control register reset value and refused offsets
        axi(1'h0, REG_CTRL, CTRL_RESET, RESP_OKAY);
        axi(1'h0, 8'h14, 32'h0, RESP_SLVERR);
        axi(1'h0, 8'h02, 32'h0, RESP_SLVERR);
        axi(1'h1, REG_LAST_VECTOR, 32'h0, RESP_SLVERR);
        $display("test registers done");
        // Zero divisor, then quotient overflow
        pulse(10'h001);
        expect_dlv(VEC_DIVIDE_ERROR, 1'h0, 1'h0);
        pulse(10'h002);
        expect_dlv(VEC_DIVIDE_ERROR, 1'h0, 1'h0);
        $display("test divide done");
        // Segment codes with a slow push side
        stall <= 4'h3;
        seg(SEG_VEC, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, SRC_INTERNAL);
        expect_dlv(SEG_VEC, 1'h1, 1'h0);
        expect_code({IDX, 3'h5}, 1'h1);
        seg(SEG_VEC, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, SRC_INTERNAL);
        expect_dlv(SEG_VEC, 1'h1, 1'h0);
        expect_code({IDX, 3'h2}, 1'h1);
        seg(SEG_VEC, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, SRC_INTERNAL);
        expect_dlv(SEG_VEC, 1'h1, 1'h0);
        expect_code(16'h0000, 1'h1);
        seg(SEG_VEC, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, SRC_INTERNAL);
        expect_dlv(SEG_VEC, 1'h1, 1'h0);
        expect_code(16'h0000, 1'h1);
        axi(1'h1, REG_CTRL, 32'h1, RESP_OKAY);
        seg(SEG_VEC, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, SRC_INTERNAL);
        expect_dlv(SEG_VEC, 1'h1, 1'h0);
        expect_code({IDX, 3'h4}, 1'h0);
        axi(1'h1, REG_CTRL, CTRL_RESET, RESP_OKAY);
        for (int s = 1; s < 4; s++)
        begin
            seg(SEG_VEC, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, src_type'(s));
            expect_dlv(SEG_VEC, 1'h0, 1'h1);
        end
        pf_code_in <= 32'h0000_0007;
        seg(VEC_PAGE_FAULT, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, SRC_INTERNAL);
        expect_dlv(VEC_PAGE_FAULT, 1'h1, 1'h0);
        chk32("page code", 32'h0000_0007, got.code);
        axi(1'h0, REG_LAST_VECTOR, {24'h0, VEC_PAGE_FAULT}, RESP_OKAY);
        axi(1'h0, REG_LAST_CODE, 32'h0000_0007, RESP_OKAY);
        $display("test segment done");
        // Every debug cause; fetch and general detect are faults
        stall <= 4'h0;
        for (int k = 0; k < DBG_W; k++)
        begin
            trap = !(k == DBG_FETCH_BIT || k == DBG_GD_BIT);
            pulse(10'h008 << k);
            expect_dlv(VEC_DEBUG, 1'h0, trap);
            axi(1'h0, REG_DEBUG_STAT, 32'h1 << k, RESP_OKAY);
            axi(1'h1, REG_DEBUG_STAT, 32'h0, RESP_OKAY);
        end
        // Fault goes at once, the step trap waits for completion
        insn_done_in <= 1'h0;
        pulse(10'h088);
        expect_dlv(VEC_DEBUG, 1'h0, 1'h0);
        tick(8);
        chk32("idle", seen, taken);
        insn_done_in <= 1'h1;
        expect_dlv(VEC_DEBUG, 1'h0, 1'h1);
        $display("test debug done");
        // Non-maskable waits for a boundary with the instruction done
        insn_boundary_in <= 1'h0;
        pulse(10'h004);
        tick(8);
        chk32("idle", seen, taken);
        insn_boundary_in <= 1'h1;
        insn_done_in <= 1'h0;
        tick(8);
        chk32("idle", seen, taken);
        insn_done_in <= 1'h1;
        expect_dlv(VEC_NMI, 1'h0, 1'h1);
        nmi_pin_in <= 1'h1;
        expect_dlv(VEC_NMI, 1'h0, 1'h1);
        nmi_pin_in <= 1'h0;
        // Two sources at once: delivered one after the other
        pulse(10'h005);
        expect_dlv(VEC_DIVIDE_ERROR, 1'h0, 1'h0);
        expect_dlv(VEC_NMI, 1'h0, 1'h1);
        $display("test nmi done");
        summarize(1'h0);
    end
endmodule
